//--- dpc_config_port.sv
// spi / i2c slave configuration port onto the byte-wide register map
module dpc_config_port
	import dpc_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR = 7'h48
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic sclk,
	input wire logic csN,
	input wire logic sdioIn,
	output logic sdioOut,
	output logic sdioOe,
	input wire logic scl,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic i2cSelect,
	output logic [15:0] regAddr,
	output logic [7:0] regWrData,
	output logic regWrEn,
	output logic regRdEn,
	input wire logic [7:0] regRdData,
	output logic lsbFirst,
	output logic addrAscend,
	output logic i2cMode
);
	import dpc_pkg::*;

	dpc_pins_if #(.W(PIN_W)) pins ();

	// sampling at 125 MHz leaves over 150 clocks per bit at 400 kHz; no glitch filter by design
	dpc_pin_sync #(.W(PIN_W), .IDLE(PIN_IDLE)) u_sync (
		.clk(clk),
		.reset(reset),
		.raw({i2cSelect, sdaIn, scl, sdioIn, csN, sclk}),
		.pins(pins)
	);

	logic [1:0] strapCnt_r;
	logic strapDone_r;
	logic i2cMode_r;
	logic [7:0] cfg_r;
	logic spiOn;
	logic i2cOn;
	logic sclkRise;
	logic sclkFall;
	logic csHigh;
	logic sdioBit;
	logic sclR;
	logic sclF;
	logic sdaBit;
	logic startCond;
	logic stopCond;

	assign spiOn = strapDone_r & ~i2cMode_r;
	assign i2cOn = strapDone_r & i2cMode_r;
	assign sclkRise = pins.rise[PIN_SCLK];
	assign sclkFall = pins.fall[PIN_SCLK];
	assign csHigh = pins.lvl[PIN_CSN];
	assign sdioBit = pins.lvl[PIN_SDIO];
	assign sclR = pins.rise[PIN_SCL];
	assign sclF = pins.fall[PIN_SCL];
	assign sdaBit = pins.lvl[PIN_SDA];
	assign startCond = pins.fall[PIN_SDA] & pins.lvl[PIN_SCL];
	assign stopCond = pins.rise[PIN_SDA] & pins.lvl[PIN_SCL];

	// protocol strap is caught once the synchroniser holds real pin values
	always_ff @(posedge clk) begin
		if (reset) begin
			strapCnt_r <= 2'h0;
			strapDone_r <= 1'b0;
			i2cMode_r <= 1'b0;
		end else if (!strapDone_r) begin
			strapCnt_r <= strapCnt_r + 2'h1;
			if (strapCnt_r == STRAP_WAIT) begin
				strapDone_r <= 1'b1;
				i2cMode_r <= pins.lvl[PIN_SEL];
			end
		end
	end

	// spi receive engine
	logic [4:0] spiCnt_r;
	logic [15:0] spiInstr_r;
	logic spiPay_r;
	logic spiRead_r;
	logic [2:0] spiBit_r;
	logic [7:0] spiRx_r;
	logic [7:0] spiData_r;
	logic [15:0] spiAddr_r;
	logic spiWr_r;
	logic spiRd_r;
	logic [15:0] instrNext;
	logic [7:0] spiByteNext;
	logic [12:0] spiStep;

	always_comb begin
		instrNext = cfg_r[LSB_FIRST_POS] ? {sdioBit, spiInstr_r[15:1]} : {spiInstr_r[14:0], sdioBit};
		spiByteNext = cfg_r[LSB_FIRST_POS] ? {sdioBit, spiRx_r[7:1]} : {spiRx_r[6:0], sdioBit};
		spiStep = cfg_r[ASCEND_POS] ? spiAddr_r[12:0] + 13'h1 : spiAddr_r[12:0] - 13'h1;
	end

	always_ff @(posedge clk) begin
		if (reset || csHigh || !spiOn) begin
			spiCnt_r <= 5'h0;
			spiInstr_r <= 16'h0000;
			spiPay_r <= 1'b0;
			spiRead_r <= 1'b0;
			spiBit_r <= 3'h0;
			spiRx_r <= 8'h00;
			spiData_r <= 8'h00;
			spiAddr_r <= 16'h0000;
			spiWr_r <= 1'b0;
			spiRd_r <= 1'b0;
		end else begin
			spiWr_r <= 1'b0;
			spiRd_r <= 1'b0;
			// every address is visited in turn, reserved ones included
			if (spiWr_r || spiRd_r) begin
				spiAddr_r <= {3'h0, spiStep};
			end
			if (sclkRise) begin
				if (!spiPay_r) begin
					spiInstr_r <= instrNext;
					spiCnt_r <= spiCnt_r + 5'h1;
					if (spiCnt_r == INSTR_LAST) begin
						spiPay_r <= 1'b1;
						spiRead_r <= instrNext[15];
						spiRd_r <= instrNext[15];
						spiAddr_r <= {3'h0, instrNext[DECODE_BITS-1:0]};
					end
				end else begin
					spiRx_r <= spiByteNext;
					spiBit_r <= spiBit_r + 3'h1;
					if (spiBit_r == BYTE_LAST) begin
						// a read fetches the next byte as soon as the current one is out
						if (spiRead_r) begin
							spiRd_r <= 1'b1;
						end else begin
							spiData_r <= spiByteNext;
							spiWr_r <= 1'b1;
						end
					end
				end
			end
		end
	end

	// serial port configuration register lives in the port, not in the map
	always_ff @(posedge clk) begin
		if (reset) begin
			cfg_r <= CFG_RESET;
		end else if (spiWr_r && spiAddr_r == CFG_ADDR) begin
			cfg_r <= spiData_r;
		end
	end

	// i2c engine
	dpc_i2c_state_t i2cState_r;
	logic [3:0] i2cBit_r;
	logic [7:0] i2cRx_r;
	logic [7:0] i2cTx_r;
	logic i2cSend_r;
	logic ackGo_r;
	logic sdaOe_r;
	logic [15:0] i2cPtr_r;
	logic [7:0] i2cData_r;
	logic i2cWr_r;
	logic i2cRd_r;
	logic rdLoad_r;
	logic cfgHold_r;
	logic [7:0] i2cRxNext;

	assign i2cRxNext = {i2cRx_r[6:0], sdaBit};

	always_ff @(posedge clk) begin
		if (reset || !i2cOn) begin
			i2cState_r <= I_IDLE;
			i2cBit_r <= 4'h0;
			i2cRx_r <= 8'h00;
			i2cTx_r <= 8'h00;
			i2cSend_r <= 1'b0;
			ackGo_r <= 1'b0;
			sdaOe_r <= 1'b0;
			i2cPtr_r <= 16'h0000;
			i2cData_r <= 8'h00;
			i2cWr_r <= 1'b0;
			i2cRd_r <= 1'b0;
		end else begin
			i2cWr_r <= 1'b0;
			i2cRd_r <= 1'b0;
			if (i2cWr_r || i2cRd_r) begin
				i2cPtr_r <= i2cPtr_r + 16'h0001;
			end
			if (rdLoad_r) begin
				i2cTx_r <= regRdData;
			end
			if (startCond) begin
				i2cState_r <= I_ADDR;
				i2cBit_r <= 4'h0;
				i2cSend_r <= 1'b0;
				sdaOe_r <= 1'b0;
			end else if (stopCond) begin
				i2cState_r <= I_IDLE;
				i2cBit_r <= 4'h0;
				i2cSend_r <= 1'b0;
				sdaOe_r <= 1'b0;
			end else if (i2cState_r != I_IDLE) begin
				if (sclR) begin
					i2cBit_r <= i2cBit_r + 4'h1;
					if (i2cBit_r < ACK_SLOT) begin
						i2cRx_r <= i2cRxNext;
					end
					if (i2cBit_r == 4'h7 && !i2cSend_r) begin
						ackGo_r <= 1'b1;
						unique case (i2cState_r)
							I_ADDR: begin
								if (i2cRxNext[7:1] != SLAVE_ADDR) begin
									i2cState_r <= I_IDLE;
									ackGo_r <= 1'b0;
								end else if (i2cRxNext[0]) begin
									i2cState_r <= I_RDATA;
									i2cRd_r <= 1'b1;
								end else begin
									i2cState_r <= I_AHI;
								end
							end
							I_AHI: begin
								i2cPtr_r[15:8] <= i2cRxNext;
								i2cState_r <= I_ALO;
							end
							I_ALO: begin
								i2cPtr_r[7:0] <= i2cRxNext;
								i2cState_r <= I_WDATA;
							end
							I_WDATA: begin
								i2cData_r <= i2cRxNext;
								i2cWr_r <= 1'b1;
							end
							I_IDLE, I_RDATA: begin
							end
						endcase
					end
					if (i2cBit_r == ACK_SLOT && i2cSend_r) begin
						if (sdaBit) begin
							i2cState_r <= I_IDLE;
							i2cSend_r <= 1'b0;
						end else begin
							i2cRd_r <= 1'b1;
						end
					end
				end
				if (sclF) begin
					if (i2cBit_r == ACK_SLOT && !i2cSend_r) begin
						sdaOe_r <= ackGo_r;
					end else if (i2cBit_r == ACK_SLOT) begin
						sdaOe_r <= 1'b0;
					end else if (i2cBit_r == FRAME_END) begin
						i2cBit_r <= 4'h0;
						i2cSend_r <= (i2cState_r == I_RDATA);
						sdaOe_r <= (i2cState_r == I_RDATA) && !i2cTx_r[7];
						i2cTx_r <= {i2cTx_r[6:0], 1'b0};
					end else if (i2cSend_r) begin
						sdaOe_r <= !i2cTx_r[7];
						i2cTx_r <= {i2cTx_r[6:0], 1'b0};
					end
				end
			end
		end
	end

	// register map port, shared by whichever protocol the strap chose
	logic [15:0] regAddr_r;
	logic [7:0] regWrData_r;
	logic regWrEn_r;
	logic regRdEn_r;
	logic rdSeen_r;

	always_ff @(posedge clk) begin
		if (reset) begin
			regAddr_r <= 16'h0000;
			regWrData_r <= 8'h00;
			regWrEn_r <= 1'b0;
			regRdEn_r <= 1'b0;
			rdSeen_r <= 1'b0;
			rdLoad_r <= 1'b0;
			cfgHold_r <= 1'b0;
		end else begin
			regWrEn_r <= (spiWr_r && spiAddr_r != CFG_ADDR) || i2cWr_r;
			regRdEn_r <= (spiRd_r && spiAddr_r != CFG_ADDR) || i2cRd_r;
			rdSeen_r <= spiRd_r || i2cRd_r;
			rdLoad_r <= rdSeen_r;
			if (spiWr_r || spiRd_r) begin
				regAddr_r <= spiAddr_r;
				regWrData_r <= spiData_r;
				cfgHold_r <= spiRd_r && spiAddr_r == CFG_ADDR;
			end else if (i2cWr_r || i2cRd_r) begin
				regAddr_r <= i2cPtr_r;
				regWrData_r <= i2cData_r;
				cfgHold_r <= 1'b0;
			end
		end
	end

	// spi read driver on the single data pin
	logic [7:0] spiTx_r;
	logic sdioOut_r;
	logic sdioOe_r;

	always_ff @(posedge clk) begin
		if (reset || csHigh || !spiOn) begin
			spiTx_r <= 8'h00;
			sdioOut_r <= 1'b0;
			sdioOe_r <= 1'b0;
		end else if (rdLoad_r) begin
			spiTx_r <= cfgHold_r ? cfg_r : regRdData;
		end else if (sclkFall && spiPay_r && spiRead_r) begin
			sdioOe_r <= 1'b1;
			sdioOut_r <= cfg_r[LSB_FIRST_POS] ? spiTx_r[0] : spiTx_r[7];
			spiTx_r <= cfg_r[LSB_FIRST_POS] ? {1'b0, spiTx_r[7:1]} : {spiTx_r[6:0], 1'b0};
		end
	end

	// open drain: the pin only ever pulls low, and scl has no driver at all
	logic sdaOut_r;
	always_ff @(posedge clk) begin
		sdaOut_r <= 1'b0;
	end

	assign sdioOut = sdioOut_r;
	assign sdioOe = sdioOe_r;
	assign sdaOut = sdaOut_r;
	assign sdaOe = sdaOe_r;
	assign regAddr = regAddr_r;
	assign regWrData = regWrData_r;
	assign regWrEn = regWrEn_r;
	assign regRdEn = regRdEn_r;
	assign lsbFirst = cfg_r[LSB_FIRST_POS];
	assign addrAscend = cfg_r[ASCEND_POS];
	assign i2cMode = i2cMode_r;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	spi_release_a: assert property (csHigh |=> !sdioOe_r) else $error("sdio driven with chip select high");
	addr_mask_a: assert property ((regWrEn_r || regRdEn_r) && !i2cMode_r |-> regAddr_r[15:13] == 3'h0)
		else $error("spi address above 13 bits");
	addr_up_a: assert property (spiWr_r && cfg_r[ASCEND_POS] && !csHigh && spiOn
		|=> spiAddr_r[12:0] == $past(spiAddr_r[12:0]) + 13'h1) else $error("address did not step up");
	addr_down_a: assert property (spiWr_r && !cfg_r[ASCEND_POS] && !csHigh && spiOn
		|=> spiAddr_r[12:0] == $past(spiAddr_r[12:0]) - 13'h1) else $error("address did not step down");
	lsb_select_a: assert property (spiWr_r && spiAddr_r == CFG_ADDR && spiData_r[LSB_FIRST_POS]
		|=> ##1 lsbFirst) else $error("lsb first not taken");
	i2c_start_a: assert property (startCond && i2cOn |=> i2cState_r == I_ADDR && i2cBit_r == 4'h0 && !sdaOe_r)
		else $error("start did not restart address phase");
	i2c_stop_a: assert property (stopCond && !startCond && i2cOn |=> i2cState_r == I_IDLE && !sdaOe_r)
		else $error("stop did not return to idle");
	i2c_nack_a: assert property (i2cOn && i2cState_r == I_RDATA && i2cSend_r && sclR && i2cBit_r == ACK_SLOT
		&& sdaBit && !startCond && !stopCond |=> i2cState_r == I_IDLE) else $error("nack ignored");
	ack_pull_a: assert property ($rose(sdaOe_r) && !i2cSend_r |-> $past(i2cBit_r) == ACK_SLOT && $past(sclF))
		else $error("ack outside ninth pulse");
	idle_quiet_a: assert property (i2cState_r == I_IDLE && $past(i2cState_r == I_IDLE) |-> !sdaOe_r)
		else $error("sda driven while idle");
	wr_pulse_a: assert property (i2cWr_r |=> regWrEn_r && regAddr_r == $past(i2cPtr_r) ##1 !regWrEn_r)
		else $error("write pulse malformed");
endmodule // dpc_config_port

//--- dpc_host_model.sv
// host master model that drives the spi and i2c pins of the port
module dpc_host_model (
	output logic sclk,
	output logic csN,
	output logic hostSdio,
	output logic scl,
	output logic hostSda,
	input wire logic sdioPad,
	input wire logic sdaPad
);
	timeunit 1ns;
	timeprecision 1ps;
	int half = 40;
	logic lsbOrder = 1'b0;
	initial begin
		sclk = 1'b0;
		csN = 1'b1;
		hostSdio = 1'b0;
		scl = 1'b1;
		hostSda = 1'b1;
	end
	// order follows what the host last programmed, never a device output
	task automatic spiBits(input logic [15:0] v, input int n, output logic [15:0] got);
		int k;
		got = '0;
		for (int i = 0; i < n; i++) begin
			k = lsbOrder ? i : n - 1 - i;
			hostSdio = v[k];
			#half sclk = 1'b1;
			got[k] = sdioPad;
			#half sclk = 1'b0;
		end
	endtask
	task automatic spiStart(input logic rd, input logic [15:0] a);
		logic [15:0] g;
		csN = 1'b0;
		#half;
		spiBits({rd, a[14:0]}, 16, g);
	endtask
	// no byte count: raising chip select is the only end of a transfer
	task automatic spiEnd();
		#half csN = 1'b1;
		hostSdio = ~hostSdio;
		#(2 * half);
	endtask
	// sda moves only mid-low so the port never sees a false start or stop
	task automatic i2cBit(input logic b, output logic got);
		#(half / 2) hostSda = b;
		#(half / 2) scl = 1'b1;
		got = sdaPad;
		#half scl = 1'b0;
	endtask
	task automatic i2cStart();
		#(half / 2) hostSda = 1'b1;
		#(half / 2) scl = 1'b1;
		#half hostSda = 1'b0;
		#half scl = 1'b0;
	endtask
	task automatic i2cStop();
		#(half / 2) hostSda = 1'b0;
		#(half / 2) scl = 1'b1;
		#half hostSda = 1'b1;
		#half;
	endtask
	task automatic i2cByte(input logic [7:0] b, input logic ackIn, output logic [7:0] got, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			i2cBit(b[i], got[i]);
		end
		i2cBit(ackIn, ack);
	endtask
endmodule // dpc_host_model

//--- dpc_pin_sync.sv
// two-stage pin synchroniser with edge detection
module dpc_pin_sync #(
	parameter int W = 6,
	parameter logic [W-1:0] IDLE = '0
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [W-1:0] raw,
	dpc_pins_if.src pins
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	// only the second stage reads the first; edges compare stages two and three
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clk) begin
			if (reset) begin
				s1_r[i] <= IDLE[i];
				s2_r[i] <= IDLE[i];
				s3_r[i] <= IDLE[i];
			end else begin
				s1_r[i] <= raw[i];
				s2_r[i] <= s1_r[i];
				s3_r[i] <= s2_r[i];
			end
		end
		assign pins.lvl[i] = s2_r[i];
		assign pins.rise[i] = s2_r[i] & ~s3_r[i];
		assign pins.fall[i] = ~s2_r[i] & s3_r[i];
	end
endmodule // dpc_pin_sync

//--- dpc_pins_if.sv
// synchronised pin levels and their edges
interface dpc_pins_if #(parameter int W = 6);
	logic [W-1:0] lvl;
	logic [W-1:0] rise;
	logic [W-1:0] fall;
	modport src(output lvl, rise, fall);
	modport dst(input lvl, rise, fall);
endinterface

//--- dpc_pkg.sv
// constants and types shared by the dual protocol configuration port
// Overview of operation
// - spi starts with 16-bit instruction: r/w, address
// - two top address bits ignored, 13 decoded
// - msb first default; config bit 6 selects lsb
// - new bit order applies to all later operations
// - ascension bit zero: address steps down; the i2c pointer always steps up
// - ascension bit one: address steps up
// - streaming never skips reserved or unmapped addresses
// - i2c works at 100 and 400 kHz
// - i2c slave only, no scl drive, no filter
// - acknowledge only own 7-bit slave address
// - data changes while clock low, stable high
// - start and stop are sda edges, scl high
// - eight bits per byte, msb first, ack slot
// - receiver acknowledges by pulling sda low, ninth pulse
// - nack leaves sda high; device returns idle
// - address byte bit eight: 0 write, 1 read
// - i2c write: two address bytes, high first
// - unlimited data bytes per i2c transfer
// - i2c read: every following byte is device data
// - spi has no byte count; chip select ends it
// - spi writes captured rising, read data driven falling
// - single bidirectional spi data pin
package dpc_pkg;
	localparam logic [15:0] CFG_ADDR = 16'h0000;
	localparam int LSB_FIRST_POS = 6;
	localparam int ASCEND_POS = 5;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [4:0] INSTR_LAST = 5'h0f;
	localparam int DECODE_BITS = 13;
	localparam logic [2:0] BYTE_LAST = 3'h7;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] FRAME_END = 4'h9;
	localparam int PIN_W = 6;
	localparam int PIN_SCLK = 0;
	localparam int PIN_CSN = 1;
	localparam int PIN_SDIO = 2;
	localparam int PIN_SCL = 3;
	localparam int PIN_SDA = 4;
	localparam int PIN_SEL = 5;
	localparam logic [PIN_W-1:0] PIN_IDLE = 6'h1a;
	localparam logic [1:0] STRAP_WAIT = 2'h3;
	typedef enum logic [2:0] {I_IDLE, I_ADDR, I_AHI, I_ALO, I_WDATA, I_RDATA} dpc_i2c_state_t;
endpackage

//--- dual_protocol_config_port_bench.sv
// self-checking bench for the dual protocol configuration port
module dual_protocol_config_port_bench
	import dpc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [15:0] addr; logic [7:0] data; logic [15:0] expAddr;} dpc_row_t;
	dpc_row_t rows[3] = '{'{16'h7fff, 8'h3c, 16'h1fff}, '{16'h0001, 8'ha5, 16'h0001}, '{16'h6abc, 8'h96, 16'h0abc}};
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic i2cSelect = 1'b0;
	logic sclk, csN, hostSdio, scl, hostSda, sdioOut, sdioOe, sdaOut, sdaOe;
	logic regWrEn, regRdEn, lsbFirst, addrAscend, i2cMode;
	logic [15:0] regAddr;
	logic [7:0] regWrData;
	logic [7:0] regRdData;
	int failures = 0;
	int n_compared = 0;
	int cycles = 0;
	logic [23:0] expQ[$];
	wire logic sdioPad = sdioOe ? sdioOut : hostSdio;
	wire logic sdaPad = (sdaOe ? sdaOut : 1'b1) & hostSda;
	// map model: each byte is a function of its address
	assign regRdData = regAddr[7:0] ^ 8'h5c;
	dpc_config_port #(.SLAVE_ADDR(7'h48)) i_dut (.clk(clk), .reset(reset), .sclk(sclk), .csN(csN),
		.sdioIn(sdioPad), .sdioOut(sdioOut), .sdioOe(sdioOe), .scl(scl), .sdaIn(sdaPad), .sdaOut(sdaOut),
		.sdaOe(sdaOe), .i2cSelect(i2cSelect), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
		.regRdEn(regRdEn), .regRdData(regRdData), .lsbFirst(lsbFirst), .addrAscend(addrAscend), .i2cMode(i2cMode));
	dpc_host_model i_host (.sclk(sclk), .csN(csN), .hostSdio(hostSdio), .scl(scl), .hostSda(hostSda),
		.sdioPad(sdioPad), .sdaPad(sdaPad));
	initial begin
		forever #4 clk = ~clk;
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// a write that was expected but never came is caught here
	task automatic done(input string name);
		repeat (20) @(posedge clk);
		chk("pending writes", 16'h0, 16'(expQ.size()));
		$display("test %s done", name);
	endtask
	task automatic doReset(input logic sel);
		@(posedge clk);
		#1;
		i2cSelect = sel;
		reset = 1'b1;
		repeat (6) @(posedge clk);
		#1;
		reset = 1'b0;
		repeat (10) @(posedge clk);
		chk("i2c mode", {15'h0, sel}, {15'h0, i2cMode});
		chk("lsb first", 16'h0, {15'h0, lsbFirst});
		chk("ascend", 16'h0, {15'h0, addrAscend});
		chk("drives", 16'h0, {14'h0, sdaOe, sdioOe});
	endtask
	task automatic spiWrite(input logic [15:0] a, input logic [7:0] d[$]);
		logic [15:0] g;
		i_host.spiStart(1'b0, a);
		foreach (d[i]) i_host.spiBits({8'h0, d[i]}, 8, g);
		i_host.spiEnd();
	endtask
	task automatic spiRead(input logic [15:0] a, input logic [7:0] e[$]);
		logic [15:0] g;
		i_host.spiStart(1'b1, a);
		foreach (e[i]) begin
			i_host.spiBits(16'h5555, 8, g);
			chk("spi read", {8'h0, e[i]}, g);
		end
		i_host.spiEnd();
	endtask
	task automatic wb(input logic [7:0] b, input logic expAck);
		logic [7:0] gotB;
		logic a;
		i_host.i2cByte(b, 1'b1, gotB, a);
		chk("i2c ack", {15'h0, expAck}, {15'h0, a});
	endtask
	task automatic rb(input logic nack, input logic [7:0] e);
		logic [7:0] gotB;
		logic a;
		i_host.i2cByte(8'hff, nack, gotB, a);
		chk("i2c read", {8'h0, e}, {8'h0, gotB});
	endtask
	always @(posedge clk) begin
		logic [23:0] e;
		if (regWrEn === 1'b1) begin
			e = expQ.size() > 0 ? expQ.pop_front() : 24'hx;
			chk("write addr", e[23:8], regAddr);
			chk("write data", {8'h0, e[7:0]}, {8'h0, regWrData});
		end
		// spi reads of the port's own config register never reach the map
		if (regRdEn === 1'b1 && i2cMode === 1'b0) begin
			chk("read addr top", 16'h0, {13'h0, regAddr[15:13]});
			chk("read not config", 16'h1, {15'h0, regAddr != CFG_ADDR});
		end
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 90000) begin
			failures++;
			$display("[ERR] watchdog expected finish seen hang");
			results();
		end
	end
	initial begin
		logic [15:0] g;
		logic b;
		doReset(1'b0);
		spiRead(CFG_ADDR, '{CFG_RESET});
		done("config reset");
		foreach (rows[i]) begin
			expQ.push_back({rows[i].expAddr, rows[i].data});
			spiWrite(rows[i].addr, '{rows[i].data});
			done("spi row");
		end
		expQ = '{{16'h0010, 8'h11}, {16'h000f, 8'h22}, {16'h000e, 8'h33}};
		// streams stay short so no run of reserved registers is crossed
		spiWrite(16'h0010, '{8'h11, 8'h22, 8'h33});
		done("spi descend");
		spiWrite(CFG_ADDR, '{8'h20});
		chk("ascend", 16'h1, {15'h0, addrAscend});
		expQ = '{{16'h0ffe, 8'h44}, {16'h0fff, 8'h55}, {16'h1000, 8'h66}};
		spiWrite(16'h0ffe, '{8'h44, 8'h55, 8'h66});
		spiRead(16'h0100, '{8'h5c, 8'h5d});
		done("spi ascend");
		spiWrite(CFG_ADDR, '{8'h60});
		chk("lsb first", 16'h1, {15'h0, lsbFirst});
		i_host.lsbOrder = 1'b1;
		expQ.push_back({16'h0234, 8'hc3});
		spiWrite(16'h0234, '{8'hc3});
		spiRead(CFG_ADDR, '{8'h60});
		done("spi lsb first");
		i_host.spiStart(1'b0, 16'h0300);
		i_host.spiBits(16'h000f, 4, g);
		i_host.spiEnd();
		done("spi abort");
		doReset(1'b1);
		i_host.half = 1250;
		i_host.i2cStart();
		wb(8'h90, 1'b0);
		wb(8'h01, 1'b0);
		wb(8'h23, 1'b0);
		expQ = '{{16'h0123, 8'ha5}, {16'h0124, 8'h5a}};
		wb(8'ha5, 1'b0);
		wb(8'h5a, 1'b0);
		i_host.i2cStop();
		done("i2c write");
		i_host.i2cStart();
		wb(8'h92, 1'b1);
		i_host.i2cStop();
		done("i2c foreign address");
		i_host.i2cStart();
		wb(8'h90, 1'b0);
		wb(8'h02, 1'b0);
		repeat (4) i_host.i2cBit(1'b1, b);
		i_host.i2cStart();
		wb(8'h90, 1'b0);
		wb(8'h04, 1'b0);
		wb(8'h56, 1'b0);
		expQ.push_back({16'h0456, 8'h77});
		wb(8'h77, 1'b0);
		i_host.i2cStop();
		done("i2c restart mid byte");
		i_host.half = 5000;
		i_host.i2cStart();
		wb(8'h91, 1'b0);
		rb(1'b0, 8'h57 ^ 8'h5c);
		rb(1'b1, 8'h58 ^ 8'h5c);
		repeat (10) @(posedge clk);
		chk("sda after nack", 16'h0, {15'h0, sdaOe});
		i_host.i2cStop();
		done("i2c read");
		results();
	end
endmodule // dual_protocol_config_port_bench
